// ==== brg_defs.vh ====
`ifndef BRG_DEFS_VH
`define BRG_DEFS_VH

// Timing
`define BRG_CLK_NS          10
`define BRG_SETTLE_NS       20000
`define BRG_SETTLE_CYC      ((`BRG_SETTLE_NS + `BRG_CLK_NS - 1) / `BRG_CLK_NS)
`define BRG_AXI_HZ          125000000
`define BRG_MDC_HZ          2500000
`define BRG_MDC_DIV         ((`BRG_AXI_HZ + 2 * `BRG_MDC_HZ - 1) / (2 * `BRG_MDC_HZ) - 1)

// MAC management register offsets
`define BRG_MAC_RX_CFG      32'h0000_0040
`define BRG_MAC_TX_CFG      32'h0000_0044
`define BRG_MAC_MDIO_CFG    32'h0000_0050
`define BRG_MAC_MDIO_CTRL   32'h0000_0054
`define BRG_MAC_MDIO_WDATA  32'h0000_0058
`define BRG_MAC_MDIO_RDATA  32'h0000_005C

// MAC register values and fields
`define BRG_RX_CFG_VAL      32'h1000_0000
`define BRG_TX_CFG_VAL      32'h1000_0000
`define BRG_MDIO_EN_VAL     32'h0000_0040
`define BRG_MDIO_RDY_BIT    7
`define BRG_OP_ADDR         2'h0
`define BRG_OP_WRITE        2'h1
`define BRG_OP_READ         2'h3

// PHY side
`define BRG_PHY_PORT        5'h00
`define BRG_PHY_DEV         5'h03
`define BRG_PHY_MODE_REG    16'h0000
`define BRG_PHY_CHK_REG     16'h0000
`define BRG_PHY_LOCK_REG    16'h0020
`define BRG_PHY_LOOP_VAL    16'h4000
`define BRG_PHY_NORM_VAL    16'h0000
`define BRG_PHY_LOOP_BIT    14
`define BRG_PHY_LOCK_BIT    0
`define BRG_PHY_RST_BIT     15

`endif

// ==== brg_axil_access.v ====
`default_nettype none
`include "brg_defs.vh"

module brg_axil_access (
  input  wire        sys_clk,
  input  wire        reset,
  input  wire        clk_en,
  input  wire        start,
  input  wire        wr,
  input  wire [31:0] addr,
  input  wire [31:0] wdata,
  output reg         done,
  output reg         err,
  output reg  [31:0] rdata,
  output reg  [31:0] m_axi_awaddr,
  output reg         m_axi_awvalid,
  input  wire        m_axi_awready,
  output reg  [31:0] m_axi_wdata,
  output reg  [3:0]  m_axi_wstrb,
  output reg         m_axi_wvalid,
  input  wire        m_axi_wready,
  input  wire [1:0]  m_axi_bresp,
  input  wire        m_axi_bvalid,
  output reg         m_axi_bready,
  output reg  [31:0] m_axi_araddr,
  output reg         m_axi_arvalid,
  input  wire        m_axi_arready,
  input  wire [31:0] m_axi_rdata,
  input  wire [1:0]  m_axi_rresp,
  input  wire        m_axi_rvalid,
  output reg         m_axi_rready
);

  localparam [1:0] P_IDLE = 2'h0;
  localparam [1:0] P_WR   = 2'h1;
  localparam [1:0] P_RD   = 2'h2;

  reg [1:0] phase;

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      phase         <= P_IDLE;
      done          <= 1'b0;
      err           <= 1'b0;
      rdata         <= 32'h0000_0000;
      m_axi_awaddr  <= 32'h0000_0000;
      m_axi_awvalid <= 1'b0;
      m_axi_wdata   <= 32'h0000_0000;
      m_axi_wstrb   <= 4'hF;
      m_axi_wvalid  <= 1'b0;
      m_axi_bready  <= 1'b0;
      m_axi_araddr  <= 32'h0000_0000;
      m_axi_arvalid <= 1'b0;
      m_axi_rready  <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      case (phase)
        P_IDLE: begin
          if (start && wr) begin
            m_axi_awaddr  <= addr;
            m_axi_wdata   <= wdata;
            m_axi_awvalid <= 1'b1;
            m_axi_wvalid  <= 1'b1;
            m_axi_bready  <= 1'b1;
            phase         <= P_WR;
          end else if (start) begin
            m_axi_araddr  <= addr;
            m_axi_arvalid <= 1'b1;
            m_axi_rready  <= 1'b1;
            phase         <= P_RD;
          end
        end
        P_WR: begin
          if (m_axi_awready)
            m_axi_awvalid <= 1'b0;
          if (m_axi_wready)
            m_axi_wvalid <= 1'b0;
          // Done only once the response is taken
          if (m_axi_bvalid) begin
            m_axi_bready <= 1'b0;
            err          <= m_axi_bresp[1];
            done         <= 1'b1;
            phase        <= P_IDLE;
          end
        end
        P_RD: begin
          if (m_axi_arready)
            m_axi_arvalid <= 1'b0;
          if (m_axi_rvalid) begin
            m_axi_rready <= 1'b0;
            rdata        <= m_axi_rdata;
            err          <= m_axi_rresp[1];
            done         <= 1'b1;
            phase        <= P_IDLE;
          end
        end
        default: phase <= P_IDLE;
      endcase
    end
  end

endmodule // brg_axil_access

`default_nettype wire

// ==== brg_sequencer.v ====
// Operation
// - Accesses are generated only when the management interface is present, else the sequencer stays idle.
// - After reset release no bus access is made until a settling interval has run out.
// - The first access enables the MAC MDIO master with a divider sized for a 125 MHz bus clock.
// - The MAC receiver and then transmitter are configured before any PHY access.
// - A PHY control register is written for PCS loopback or normal operation per the loopback select.
// - A PHY status read after the mode write confirms the mode took effect.
// - In loopback, setup ends after the check read and the pattern generator enable is raised.
// - In normal mode a second PHY status register with reset and block lock state is read.
// - In normal mode that register is re-read until block lock shows and reset is clear, without advancing.
// - After block lock in normal mode the pattern generator enable is raised.
// - The running state is left only on reset or on the loopback select becoming asserted.
`default_nettype none
`include "brg_defs.vh"

module brg_sequencer #(
  parameter MGMT_PRESENT = 1
) (
  input  wire        sys_clk,
  input  wire        reset,
  input  wire        clk_en,
  input  wire        loopback_sel,
  output reg         pat_gen_en,
  output reg         phy_ready,
  output reg         bus_error,
  output wire [31:0] m_axi_awaddr,
  output wire        m_axi_awvalid,
  input  wire        m_axi_awready,
  output wire [31:0] m_axi_wdata,
  output wire [3:0]  m_axi_wstrb,
  output wire        m_axi_wvalid,
  input  wire        m_axi_wready,
  input  wire [1:0]  m_axi_bresp,
  input  wire        m_axi_bvalid,
  output wire        m_axi_bready,
  output wire [31:0] m_axi_araddr,
  output wire        m_axi_arvalid,
  input  wire        m_axi_arready,
  input  wire [31:0] m_axi_rdata,
  input  wire [1:0]  m_axi_rresp,
  input  wire        m_axi_rvalid,
  output wire        m_axi_rready
);

  localparam [3:0] S_SETTLE  = 4'h0;
  localparam [3:0] S_MCFG    = 4'h1;
  localparam [3:0] S_RXCFG   = 4'h2;
  localparam [3:0] S_TXCFG   = 4'h3;
  localparam [3:0] S_MD_ADDR = 4'h4;
  localparam [3:0] S_MD_AGO  = 4'h5;
  localparam [3:0] S_MD_APOL = 4'h6;
  localparam [3:0] S_MD_WDAT = 4'h7;
  localparam [3:0] S_MD_GO   = 4'h8;
  localparam [3:0] S_MD_POLL = 4'h9;
  localparam [3:0] S_MD_RDAT = 4'hA;
  localparam [3:0] S_EVAL    = 4'hB;
  localparam [3:0] S_RUN     = 4'hC;

  localparam [1:0] J_SET  = 2'h0;
  localparam [1:0] J_CHK  = 2'h1;
  localparam [1:0] J_LOCK = 2'h2;

  localparam integer SETTLE_CYC  = `BRG_SETTLE_CYC;
  // Count fits 12 bits, cut on purpose
  localparam [31:0]  SETTLE_SPAN = SETTLE_CYC - 1;
  localparam [11:0]  SETTLE_LAST = SETTLE_SPAN[11:0];
  localparam integer MDC_DIV     = `BRG_MDC_DIV;
  localparam [31:0]  MDIO_CFG    = `BRG_MDIO_EN_VAL | MDC_DIV;

  reg  [3:0]  state;
  reg  [11:0] settle_cnt;
  reg  [1:0]  job;
  reg         loop_mode;
  reg         loop_prev;
  reg         pend;
  reg         start;
  reg         acc_wr;
  reg  [31:0] acc_addr;
  reg  [31:0] acc_wdata;
  reg         next_wr;
  reg  [31:0] next_addr;
  reg  [31:0] next_wdata;
  reg  [15:0] job_reg;
  reg  [1:0]  job_op;
  wire        done;
  wire        err;
  wire [31:0] rdata;
  wire        mdio_rdy;
  wire [31:0] ctrl_addr_op;
  wire [31:0] ctrl_data_op;

  assign mdio_rdy     = rdata[`BRG_MDIO_RDY_BIT];
  assign ctrl_addr_op = {3'h0, `BRG_PHY_PORT, 3'h0, `BRG_PHY_DEV, `BRG_OP_ADDR, 3'h1, 11'h000};
  assign ctrl_data_op = {3'h0, `BRG_PHY_PORT, 3'h0, `BRG_PHY_DEV, job_op, 3'h1, 11'h000};

  always @* begin
    case (job)
      J_SET:   job_reg = `BRG_PHY_MODE_REG;
      J_CHK:   job_reg = `BRG_PHY_CHK_REG;
      default: job_reg = `BRG_PHY_LOCK_REG;
    endcase
    job_op = (job == J_SET) ? `BRG_OP_WRITE : `BRG_OP_READ;
  end

  // Access wanted by the current state
  always @* begin
    next_wr    = 1'b1;
    next_addr  = `BRG_MAC_MDIO_CTRL;
    next_wdata = 32'h0000_0000;
    case (state)
      S_MCFG: begin
        next_addr  = `BRG_MAC_MDIO_CFG;
        next_wdata = MDIO_CFG;
      end
      S_RXCFG: begin
        next_addr  = `BRG_MAC_RX_CFG;
        next_wdata = `BRG_RX_CFG_VAL;
      end
      S_TXCFG: begin
        next_addr  = `BRG_MAC_TX_CFG;
        next_wdata = `BRG_TX_CFG_VAL;
      end
      S_MD_ADDR: begin
        next_addr  = `BRG_MAC_MDIO_WDATA;
        next_wdata = {16'h0000, job_reg};
      end
      S_MD_AGO:  next_wdata = ctrl_addr_op;
      S_MD_APOL: next_wr = 1'b0;
      S_MD_WDAT: begin
        next_addr  = `BRG_MAC_MDIO_WDATA;
        next_wdata = {16'h0000, loop_mode ? `BRG_PHY_LOOP_VAL : `BRG_PHY_NORM_VAL};
      end
      S_MD_GO:   next_wdata = ctrl_data_op;
      S_MD_POLL: next_wr = 1'b0;
      S_MD_RDAT: begin
        next_wr   = 1'b0;
        next_addr = `BRG_MAC_MDIO_RDATA;
      end
      default: next_wr = 1'b1;
    endcase
  end

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state      <= S_SETTLE;
      settle_cnt <= 12'h000;
      job        <= J_SET;
      loop_mode  <= 1'b0;
      loop_prev  <= 1'b0;
      pend       <= 1'b0;
      start      <= 1'b0;
      acc_wr     <= 1'b0;
      acc_addr   <= 32'h0000_0000;
      acc_wdata  <= 32'h0000_0000;
      pat_gen_en <= 1'b0;
      phy_ready  <= 1'b0;
      bus_error  <= 1'b0;
    end else if (clk_en) begin
      start     <= 1'b0;
      loop_prev <= loopback_sel;
      if (done && err)
        bus_error <= 1'b1;
      case (state)
        S_SETTLE: begin
          // Without the management interface nothing is ever issued
          if (MGMT_PRESENT != 0) begin
            if (settle_cnt == SETTLE_LAST)
              state <= S_MCFG;
            else
              settle_cnt <= settle_cnt + 12'h001;
          end
        end
        S_EVAL: begin
          state <= S_MD_ADDR;
          case (job)
            J_SET: job <= J_CHK;
            J_CHK: begin
              if (rdata[`BRG_PHY_LOOP_BIT] != loop_mode)
                job <= J_SET;
              else if (loop_mode)
                state <= S_RUN;
              else
                job <= J_LOCK;
            end
            default: begin
              // Keep polling until locked and out of reset
              if (rdata[`BRG_PHY_LOCK_BIT] && !rdata[`BRG_PHY_RST_BIT])
                state <= S_RUN;
            end
          endcase
        end
        S_RUN: begin
          pat_gen_en <= 1'b1;
          phy_ready  <= 1'b1;
          // Edge, not level: in loopback the select stays high while running
          if (loopback_sel && !loop_prev) begin
            pat_gen_en <= 1'b0;
            phy_ready  <= 1'b0;
            loop_mode  <= 1'b1;
            job        <= J_SET;
            state      <= S_MD_ADDR;
          end
        end
        default: begin
          if (!pend) begin
            start     <= 1'b1;
            pend      <= 1'b1;
            acc_wr    <= next_wr;
            acc_addr  <= next_addr;
            acc_wdata <= next_wdata;
          end else if (done) begin
            pend <= 1'b0;
            case (state)
              S_MCFG:    state <= S_RXCFG;
              S_RXCFG:   state <= S_TXCFG;
              S_TXCFG: begin
                loop_mode <= loopback_sel;
                job       <= J_SET;
                state     <= S_MD_ADDR;
              end
              S_MD_ADDR: state <= S_MD_AGO;
              S_MD_AGO:  state <= S_MD_APOL;
              S_MD_APOL: begin
                if (mdio_rdy)
                  state <= (job == J_SET) ? S_MD_WDAT : S_MD_GO;
              end
              S_MD_WDAT: state <= S_MD_GO;
              S_MD_GO:   state <= S_MD_POLL;
              S_MD_POLL: begin
                if (mdio_rdy)
                  state <= (job == J_SET) ? S_EVAL : S_MD_RDAT;
              end
              S_MD_RDAT: state <= S_EVAL;
              default:   state <= S_SETTLE;
            endcase
          end
        end
      endcase
    end
  end

  brg_axil_access u_access (
    .sys_clk       (sys_clk),
    .reset         (reset),
    .clk_en        (clk_en),
    .start         (start),
    .wr            (acc_wr),
    .addr          (acc_addr),
    .wdata         (acc_wdata),
    .done          (done),
    .err           (err),
    .rdata         (rdata),
    .m_axi_awaddr  (m_axi_awaddr),
    .m_axi_awvalid (m_axi_awvalid),
    .m_axi_awready (m_axi_awready),
    .m_axi_wdata   (m_axi_wdata),
    .m_axi_wstrb   (m_axi_wstrb),
    .m_axi_wvalid  (m_axi_wvalid),
    .m_axi_wready  (m_axi_wready),
    .m_axi_bresp   (m_axi_bresp),
    .m_axi_bvalid  (m_axi_bvalid),
    .m_axi_bready  (m_axi_bready),
    .m_axi_araddr  (m_axi_araddr),
    .m_axi_arvalid (m_axi_arvalid),
    .m_axi_arready (m_axi_arready),
    .m_axi_rdata   (m_axi_rdata),
    .m_axi_rresp   (m_axi_rresp),
    .m_axi_rvalid  (m_axi_rvalid),
    .m_axi_rready  (m_axi_rready)
  );

endmodule // brg_sequencer

`default_nettype wire

// ==== brg_seq_properties.sv ====
`default_nettype none
module brg_seq_checker (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        clk_en,
  input wire logic        loopback_sel,
  input wire logic        pat_gen_en,
  input wire logic        phy_ready,
  input wire logic        bus_error,
  input wire logic [31:0] m_axi_awaddr,
  input wire logic        m_axi_awvalid,
  input wire logic        m_axi_awready,
  input wire logic [31:0] m_axi_wdata,
  input wire logic [3:0]  m_axi_wstrb,
  input wire logic        m_axi_wvalid,
  input wire logic        m_axi_bvalid,
  input wire logic        m_axi_bready,
  input wire logic [31:0] m_axi_araddr,
  input wire logic        m_axi_arvalid,
  input wire logic        m_axi_arready,
  input wire logic        m_axi_rready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] settle;
  logic        first_w;
  // Enabled edges only; frozen cycles do not shorten the settle wait
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      settle  <= 12'h000;
      first_w <= 1'b1;
    end else begin
      if (clk_en && settle != 12'h7D0) settle <= settle + 12'h001;
      if (m_axi_awvalid && m_axi_awready) first_w <= 1'b0;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  AST_SETTLE: assert property ((m_axi_awvalid || m_axi_arvalid) |-> settle == 12'h7D0)
    else $error("bus access before settle interval");
  // 125 MHz / (2 * 2.5 MHz) - 1 = 24, plus enable bit 6
  AST_FIRST_WRITE: assert property (m_axi_awvalid && first_w |->
    m_axi_awaddr == 32'h0000_0050 && m_axi_wdata == 32'h0000_0058)
    else $error("first write is not the MDIO setup");
  AST_AW_HOLD: assert property (m_axi_awvalid && !m_axi_awready |=>
    m_axi_awvalid && $stable(m_axi_awaddr) && $stable(m_axi_wdata))
    else $error("write request dropped or changed");
  AST_AR_HOLD: assert property (m_axi_arvalid && !m_axi_arready |=> m_axi_arvalid && $stable(m_axi_araddr))
    else $error("read request dropped or changed");
  AST_ONE_ACCESS: assert property ((m_axi_bready || m_axi_awvalid) |-> !(m_axi_arvalid || m_axi_rready))
    else $error("read and write outstanding together");
  AST_B_WAIT: assert property (m_axi_bready && !m_axi_bvalid |=> m_axi_bready)
    else $error("write response not awaited");
  AST_AW_W_TOGETHER: assert property ($rose(m_axi_awvalid) |-> m_axi_wvalid && m_axi_bready && m_axi_wstrb == 4'hF)
    else $error("write address and data not issued together");
  AST_RUN_QUIET: assert property (pat_gen_en |-> phy_ready && !m_axi_awvalid && !m_axi_arvalid)
    else $error("access while generator enabled");
  AST_RUN_HOLD: assert property (pat_gen_en && !loopback_sel |=> pat_gen_en)
    else $error("running state left without cause");
  AST_ERR_STICKY: assert property (bus_error |=> bus_error)
    else $error("bus error flag cleared");
  cover property ($rose(pat_gen_en));
  cover property (phy_ready && $rose(loopback_sel));
  cover property ($rose(bus_error));
endmodule // brg_seq_checker
bind brg_sequencer brg_seq_checker u_brg_seq_checker (.sys_clk, .reset, .clk_en, .loopback_sel, .pat_gen_en,
  .phy_ready, .bus_error, .m_axi_awaddr, .m_axi_awvalid, .m_axi_awready, .m_axi_wdata, .m_axi_wstrb,
  .m_axi_wvalid, .m_axi_bvalid, .m_axi_bready, .m_axi_araddr, .m_axi_arvalid, .m_axi_arready, .m_axi_rready);
`default_nettype wire

// ==== brg_mac_model.sv ====
`default_nettype none
module brg_mac_model (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic [1:0]  lat,
  input wire logic [3:0]  lock_n,
  input wire logic        err_inj,
  input wire logic [31:0] awaddr,
  input wire logic        awvalid,
  input wire logic [31:0] wdata,
  input wire logic        wvalid,
  input wire logic        bready,
  input wire logic [31:0] araddr,
  input wire logic        arvalid,
  input wire logic        rready,
  output var logic        awready,
  output var logic        wready,
  output var logic [1:0]  bresp,
  output var logic        bvalid,
  output var logic        arready,
  output var logic [31:0] rdata,
  output var logic        rvalid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0]  dly;
  logic [2:0]  busy;
  logic [3:0]  polls;
  logic [15:0] wd, ra, mode, rd;
  logic [31:0] rbuf;
  logic        wpend, rpend;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      {awready, wready, bvalid, arready, rvalid, wpend, rpend} <= 7'h00;
      {dly, busy, polls, bresp} <= 11'h000;
      {wd, ra, mode, rd} <= 64'h0000_0000_0000_0000;
      rdata <= 32'h0000_0000;
    end else begin
      {awready, wready, arready} <= 3'h0;
      if (dly != 2'h0) dly <= dly - 2'h1;
      if (busy != 3'h0) busy <= busy - 3'h1;
      if (bvalid && bready) bvalid <= 1'b0;
      if (rvalid && rready) rvalid <= 1'b0;
      // Released read data keeps changing so a stale capture shows up
      if (!rvalid) rdata <= ~rdata;
      if (wpend && dly == 2'h0) begin
        {bvalid, wpend} <= 2'h2;
        bresp <= err_inj ? 2'h2 : 2'h0;
      end
      if (rpend && dly == 2'h0) begin
        {rvalid, rpend} <= 2'h2;
        rdata <= rbuf;
      end
      if (awvalid && wvalid && !awready && !wpend && !bvalid && !rpend && !rvalid) begin
        {awready, wready, wpend} <= 3'h7;
        dly <= lat;
        if (awaddr == 32'h0000_0058) wd <= wdata[15:0];
        if (awaddr == 32'h0000_0054) begin
          busy <= 3'h7;
          if (wdata[15:14] == 2'h0) ra <= wd;
          if (wdata[15:14] == 2'h1 && ra == 16'h0000) {mode, polls} <= {wd, 4'h0};
          if (wdata[15:14] == 2'h3) begin
            rd <= ra == 16'h0000 ? mode : (polls >= lock_n ? 16'h0001 : 16'h8000);
            if (ra != 16'h0000) polls <= polls + 4'h1;
          end
        end
      end
      if (arvalid && !arready && !rpend && !rvalid && !wpend && !bvalid) begin
        {arready, rpend} <= 2'h3;
        dly <= lat;
        rbuf <= araddr == 32'h0000_0054 ? {24'h00_0000, busy == 3'h0, 7'h00} : {16'h0000, rd};
      end
    end
  end
endmodule // brg_mac_model
`default_nettype wire

// ==== tb_top.sv ====
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, loopback_sel = 1'b0, err_inj = 1'b0, settle = 1'b1;
  logic [7:0]  r = 8'h5C;
  logic [1:0]  lat = 2'h0;
  logic [3:0]  lock_n = 4'h0;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic        pat_gen_en, phy_ready, bus_error;
  logic [63:0] q[$];
  int          fails = 0, n_compared = 0;
  always #5 sys_clk = ~sys_clk;
  brg_sequencer u_brg_sequencer (.sys_clk, .reset, .clk_en, .loopback_sel, .pat_gen_en, .phy_ready, .bus_error,
    .m_axi_awaddr(awaddr), .m_axi_awvalid(awvalid), .m_axi_awready(awready), .m_axi_wdata(wdata),
    .m_axi_wstrb(wstrb), .m_axi_wvalid(wvalid), .m_axi_wready(wready), .m_axi_bresp(bresp),
    .m_axi_bvalid(bvalid), .m_axi_bready(bready), .m_axi_araddr(araddr), .m_axi_arvalid(arvalid),
    .m_axi_arready(arready), .m_axi_rdata(rdata), .m_axi_rresp({err_inj, 1'b0}), .m_axi_rvalid(rvalid),
    .m_axi_rready(rready));
  brg_mac_model u_brg_mac_model (.sys_clk, .reset, .lat, .lock_n, .err_inj, .awaddr, .awvalid, .wdata, .wvalid,
    .bready, .araddr, .arvalid, .rready, .awready, .wready, .bresp, .bvalid, .arready, .rdata, .rvalid);
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // Random enable gaps only while settling, a frozen master cannot follow a live slave
  always @(posedge sys_clk) begin
    r <= nxt(r);
    lat <= r[1:0];
    clk_en <= settle ? (r[2] | r[3]) : 1'b1;
  end
  task automatic give_verdict;
    if (fails == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic push(input logic [31:0] a, input logic [31:0] d);
    q.push_back({a, d});
  endtask
  task automatic mdio(input logic [1:0] op, input logic [15:0] ra, input logic [15:0] v);
    push(32'h0000_0058, {16'h0000, ra});
    push(32'h0000_0054, 32'h0003_0800);
    if (op == 2'h1) push(32'h0000_0058, {16'h0000, v});
    push(32'h0000_0054, 32'h0003_0800 | {16'h0000, op, 14'h0000});
    if (op == 2'h3) push(32'h0000_005C, 32'h0000_0000);
  endtask
  task automatic start_up(input logic [15:0] mode);
    push(32'h0000_0050, 32'h0000_0058);
    push(32'h0000_0040, 32'h1000_0000);
    push(32'h0000_0044, 32'h1000_0000);
    mdio(2'h1, 16'h0000, mode);
    mdio(2'h3, 16'h0000, 16'h0000);
    @(posedge sys_clk);
    settle <= 1'b1;
    reset <= 1'b0;
    repeat (1500) @(posedge sys_clk);
    settle <= 1'b0;
  endtask
  task automatic wait_run(input logic val);
    int i;
    for (i = 0; i < 20000 && pat_gen_en !== val; i++) @(posedge sys_clk);
    if (pat_gen_en !== val) begin
      fails++;
      give_verdict();
    end
  endtask
  // Every accepted write must be the next one the sequence model predicts
  always @(posedge sys_clk) begin
    if (awvalid && awready) chk({awaddr, wdata}, q.size() > 0 ? q.pop_front() : 64'h0000_0000_0000_0000);
    // Status polls may repeat freely, any other read must be the predicted one
    if (arvalid && arready && araddr != 32'h0000_0054)
      chk({araddr, 32'h0000_0000}, q.size() > 0 ? q.pop_front() : 64'h0000_0000_0000_0000);
  end
  initial begin
    repeat (9) @(posedge sys_clk);
    lock_n <= {2'h0, r[4:3]};
    start_up(16'h0000);
    repeat (1) mdio(2'h3, 16'h0020, 16'h0000);
    for (int k = 0; k < lock_n; k++) mdio(2'h3, 16'h0020, 16'h0000);
    wait_run(1'b1);
    chk(64'(q.size()), 64'h0);
    chk(64'(phy_ready), 64'h1);
    repeat (30) @(posedge sys_clk);
    chk(64'(pat_gen_en), 64'h1);
    mdio(2'h1, 16'h0000, 16'h4000);
    mdio(2'h3, 16'h0000, 16'h0000);
    loopback_sel <= 1'b1;
    wait_run(1'b0);
    wait_run(1'b1);
    chk(64'(q.size()), 64'h0);
    chk(64'(bus_error), 64'h0);
    err_inj <= 1'b1;
    reset <= 1'b1;
    q.delete();
    repeat (3) @(posedge sys_clk);
    chk({pat_gen_en, phy_ready, bus_error, awvalid, arvalid}, 64'h0);
    start_up(16'h4000);
    wait_run(1'b1);
    chk(64'(q.size()), 64'h0);
    chk(64'(bus_error), 64'h1);
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
